/* File: hw/flcfg_top.sv */
// Fault and limit configuration plus temperature converter control registers
// How it works
// - Fault/limit register at pointer 5, sixteen bits, zero reset, fields at documented bits.
// - Chop field picks fixed, off, fully random or chopping-only random clocking.
// - Outer input fault comparators act only when the outer group is on.
// - Inner amplifier fault comparators act only when the inner group is on.
// - Outer fault forces output to the outer fault level unless an inner fault also trips.
// - Inner fault forces output to the inner fault level.
// - Over and under clamps act only while scale limit is on.
// - Over-scale code picks seven descending levels; code seven is reserved.
// - Under-scale code picks eight ascending levels.
// - Converter control at pointer 6, zero reset, bits 15:14 reserved.
// - Double speed halves the shortest external-mode conversion; not in internal mode.
// - Writing one to start runs one conversion; cleared on completion unless continuous is set.
// - Bias bit switches the sense pin current source.
// - Continuous bit makes the converter run back to back.
// - Own-reference bit picks the internal reference over the external one.
// - External reference code picks main, excitation or supply; three is reserved.
// - Mux code picks the converter input pair.
// - Gain code picks one, two, four or eight.
// - Resolution field picks resolution and conversion time.
// - Internal mode resolutions take 3 to 24 ms, doubling per step.
`timescale 1ns/100ps
module flcfg_top
   import flcfg_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire flcfg_pkg::flcfg_req_t REQ,
   input wire flcfg_pkg::flcfg_cmp_t CMP,
   output logic [15:0] RDATA,
   output logic RVALID,
   output flcfg_pkg::flcfg_chop_t CHOP,
   output flcfg_pkg::flcfg_out_t OUT_CTRL,
   output flcfg_pkg::flcfg_adc_t ADC_CTRL,
   output logic CONV_DONE
);
   import flcfg_pkg::*;

   // A zero millisecond would make every conversion end at once; a negative one would wrap to a huge length
   if (CYC_MS < 1) begin : g_bad_cyc_ms
      $error("CYC_MS must be positive");
   end

   localparam int CNT_W = 32;

   logic [15:0] fl_r;
   logic [15:0] tc_r;
   logic [15:0] fl_nxt;
   logic [15:0] tc_nxt;
   flcfg_cmp_t cmp_s1_r;
   flcfg_cmp_t cmp_s2_r;
   logic restart_r;
   logic busy;
   logic done;
   logic [CNT_W-1:0] len;

   // Request arrives from the serial engine on this clock as a completed transaction
   wire wr_fl = REQ.wr && (REQ.ptr == FAULT_LIMIT_PTR);
   wire wr_tc = REQ.wr && (REQ.ptr == TEMP_CTRL_PTR);
   wire start_wr = wr_tc && REQ.wdata[START_BIT];
   wire cont = tc_r[CONT_BIT];
   wire internal = tc_r[SENSE_BIT];
   wire own_ref = tc_r[OWNREF_BIT];
   wire [1:0] res = tc_r[RES_HI:RES_LO];
   wire speed = tc_r[SPEED_BIT] && !internal;

   // Written bits land as stored; reserved bits are held at zero
   assign fl_nxt = wr_fl ? (REQ.wdata & FAULT_LIMIT_WMASK) : fl_r;

   // Start bit self-clears on completion unless continuous is set; a new one-write wins over the clear
   always_comb begin
      tc_nxt = tc_r;
      if (wr_tc) begin
         tc_nxt = REQ.wdata & TEMP_CTRL_WMASK;
         tc_nxt[START_BIT] = REQ.wdata[START_BIT] | (tc_r[START_BIT] & !done);
      end else if (done && !cont) begin
         tc_nxt[START_BIT] = 1'b0;
      end
   end

   // Base time per resolution code and sensing mode
   function automatic int base_ms(input logic intm, input logic oref, input logic [1:0] r);
      int ms;
      ms = 0;
      if (intm) begin
         ms = INT_BASE_MS << r;
      end else begin
         case (r)
            2'h0: ms = oref ? OWN_REF_BASE_MS : EXT_BASE_MS;
            2'h1: ms = oref ? OWN_STEP1_MS : EXT_STEP1_MS;
            2'h2: ms = oref ? OWN_STEP2_MS : EXT_STEP2_MS;
            default: ms = oref ? OWN_STEP3_MS : EXT_STEP3_MS;
         endcase
      end
      return ms;
   endfunction

   // Double speed only shortens the lowest resolution with external reference
   wire halve = speed && !own_ref && (res == 2'h0);
   wire [CNT_W-1:0] full_len = CNT_W'(base_ms(internal, own_ref, res) * CYC_MS);
   assign len = halve ? (full_len >> 1) : full_len;

   wire run_req = cont || tc_r[START_BIT];
   wire restart_nxt = start_wr || (cont && !busy && !restart_r) ||
                      (wr_tc && REQ.wdata[CONT_BIT] && !cont);

   flcfg_conv_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .clk(CLK),
      .rst_n(RST_N),
      .restart(restart_r),
      .enable(run_req),
      .length(len),
      .busy(busy),
      .done(done)
   );

   // Comparator flags are asynchronous analog outputs
   wire outer_hit = fl_r[OUTER_ON_BIT] && (|cmp_s2_r.outer_trip);
   wire inner_hit = fl_r[INNER_ON_BIT] && (|cmp_s2_r.inner_trip);
   // Inner group takes priority when both groups trip at once
   wire force_lvl = inner_hit ? fl_r[INNER_LVL_BIT] : fl_r[OUTER_LVL_BIT];
   wire clamp_on = fl_r[LIMIT_ON_BIT];
   wire [2:0] over_sel = fl_r[OVER_HI:OVER_LO];
   // Reserved over-scale code clamps at the lowest documented level rather than floating
   wire [2:0] over_eff = (over_sel == OVER_RESERVED) ? (OVER_RESERVED - 3'h1) : over_sel;
   wire [7:0] over_code = 8'h01 << over_eff;
   wire [7:0] under_code = 8'h01 << fl_r[UNDER_HI:UNDER_LO];

   flcfg_out_t out_nxt;
   flcfg_adc_t adc_nxt;
   always_comb begin
      out_nxt.force_on = outer_hit || inner_hit;
      out_nxt.force_level = force_lvl;
      out_nxt.clamp_on = clamp_on && (cmp_s2_r.over_trip || cmp_s2_r.under_trip);
      out_nxt.over_level_code = clamp_on ? over_code : 8'h00;
      out_nxt.under_level_code = clamp_on ? under_code : 8'h00;
      adc_nxt.run = busy;
      adc_nxt.restart = restart_r;
      adc_nxt.double_speed = halve;
      adc_nxt.internal_sensing_mode = internal;
      adc_nxt.bias_on = tc_r[BIAS_BIT];
      adc_nxt.own_ref = own_ref;
      adc_nxt.ext_ref = own_ref ? 2'h0 : tc_r[REFSEL_HI:REFSEL_LO];
      adc_nxt.mux = tc_r[MUX_HI:MUX_LO];
      adc_nxt.gain = 4'h1 << tc_r[GAIN_HI:GAIN_LO];
      adc_nxt.res = res;
   end

   wire [15:0] rd_mux = (REQ.ptr == FAULT_LIMIT_PTR) ? fl_r :
                        (REQ.ptr == TEMP_CTRL_PTR) ? tc_r : 16'h0000;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         fl_r <= FAULT_LIMIT_RST;
         tc_r <= TEMP_CTRL_RST;
         cmp_s1_r <= '0;
         cmp_s2_r <= '0;
         restart_r <= 1'b0;
         RDATA <= 16'h0000;
         RVALID <= 1'b0;
         CHOP <= FLCFG_CHOP_FIXED;
         OUT_CTRL <= '0;
         ADC_CTRL <= '0;
         CONV_DONE <= 1'b0;
      end else begin
         fl_r <= fl_nxt;
         tc_r <= tc_nxt;
         cmp_s1_r <= CMP;
         cmp_s2_r <= cmp_s1_r;
         restart_r <= restart_nxt;
         RDATA <= REQ.rd ? rd_mux : RDATA;
         RVALID <= REQ.rd;
         CHOP <= flcfg_chop_t'(fl_r[CHOP_HI:CHOP_LO]);
         OUT_CTRL <= out_nxt;
         ADC_CTRL <= adc_nxt;
         CONV_DONE <= done;
      end
   end
endmodule

/* File: hw/flcfg_pkg.sv */
// Register map, field positions and timing constants of the fault, limit and temperature block
package flcfg_pkg;
   localparam int PTR_W = 5;
   localparam int REG_W = 16;
   localparam logic [4:0] FAULT_LIMIT_PTR = 5'h05;
   localparam logic [4:0] TEMP_CTRL_PTR = 5'h06;
   localparam logic [15:0] FAULT_LIMIT_RST = 16'h0000;
   localparam logic [15:0] TEMP_CTRL_RST = 16'h0000;
   // Fault and limit fields
   localparam int CHOP_HI = 13;
   localparam int CHOP_LO = 12;
   localparam int OUTER_ON_BIT = 11;
   localparam int INNER_ON_BIT = 10;
   localparam int OUTER_LVL_BIT = 9;
   localparam int INNER_LVL_BIT = 8;
   localparam int LIMIT_ON_BIT = 6;
   localparam int OVER_HI = 5;
   localparam int OVER_LO = 3;
   localparam int UNDER_HI = 2;
   localparam int UNDER_LO = 0;
   localparam logic [15:0] FAULT_LIMIT_WMASK = 16'h3f7f;
   // Temperature converter fields
   localparam int SPEED_BIT = 13;
   localparam int START_BIT = 12;
   localparam int BIAS_BIT = 11;
   localparam int CONT_BIT = 10;
   localparam int SENSE_BIT = 9;
   localparam int OWNREF_BIT = 8;
   localparam int REFSEL_HI = 7;
   localparam int REFSEL_LO = 6;
   localparam int MUX_HI = 5;
   localparam int MUX_LO = 4;
   localparam int GAIN_HI = 3;
   localparam int GAIN_LO = 2;
   localparam int RES_HI = 1;
   localparam int RES_LO = 0;
   localparam logic [15:0] TEMP_CTRL_WMASK = 16'h3fff;
   localparam logic [2:0] OVER_RESERVED = 3'h7;
   localparam logic [1:0] REF_RESERVED = 2'h3;
   // Conversion times in ms per resolution code, base values at the lowest code
   localparam int CLK_MHZ = 125;
   localparam int INT_BASE_MS = 3;
   localparam int EXT_BASE_MS = 6;
   localparam int OWN_REF_BASE_MS = 8;
   localparam int EXT_STEP1_MS = 24;
   localparam int EXT_STEP2_MS = 50;
   localparam int EXT_STEP3_MS = 100;
   localparam int OWN_STEP1_MS = 32;
   localparam int OWN_STEP2_MS = 64;
   localparam int OWN_STEP3_MS = 128;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;

   typedef enum logic [1:0] {FLCFG_CHOP_FIXED, FLCFG_CHOP_OFF, FLCFG_CHOP_RAND_ALL,
                             FLCFG_CHOP_RAND_DAC} flcfg_chop_t;
   typedef enum logic [1:0] {FLCFG_REF_MAIN, FLCFG_REF_EXC, FLCFG_REF_SUPPLY,
                             FLCFG_REF_NONE} flcfg_ref_t;

   typedef struct packed {
      logic [4:0] ptr;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } flcfg_req_t;

   typedef struct packed {
      logic [3:0] outer_trip;
      logic [4:0] inner_trip;
      logic over_trip;
      logic under_trip;
   } flcfg_cmp_t;

   typedef struct packed {
      logic force_on;
      logic force_level;
      logic clamp_on;
      logic [7:0] over_level_code;
      logic [7:0] under_level_code;
   } flcfg_out_t;

   typedef struct packed {
      logic run;
      logic restart;
      logic double_speed;
      logic internal_sensing_mode;
      logic bias_on;
      logic own_ref;
      logic [1:0] ext_ref;
      logic [1:0] mux;
      logic [3:0] gain;
      logic [1:0] res;
   } flcfg_adc_t;
endpackage

/* File: hw/flcfg_conv_timer.sv */
// Conversion timer: counts one temperature conversion and pulses on completion
`timescale 1ns/100ps
module flcfg_conv_timer #(
   parameter int CNT_W = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic enable,
   input wire logic [CNT_W-1:0] length,
   output logic busy,
   output logic done
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic busy_nxt;
   logic done_nxt;
   wire last = busy && (cnt_r <= CNT_W'(1));

   // Restart drops the partial count and begins a fresh conversion
   assign cnt_nxt = restart ? length : (busy && !last) ? cnt_r - CNT_W'(1) : cnt_r;
   assign busy_nxt = restart ? 1'b1 : (last || !enable) ? 1'b0 : busy;
   assign done_nxt = !restart && last && enable;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         busy <= busy_nxt;
         done <= done_nxt;
      end
   end
endmodule

/* File: bench/flcfg_checker.sv */
// Assertion checker watching the ports of the configuration block
`timescale 1ns/100ps
module flcfg_checker
   import flcfg_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire flcfg_pkg::flcfg_req_t REQ,
   input wire flcfg_pkg::flcfg_cmp_t CMP,
   input wire logic [15:0] RDATA,
   input wire logic RVALID,
   input wire flcfg_pkg::flcfg_chop_t CHOP,
   input wire flcfg_pkg::flcfg_out_t OUT_CTRL,
   input wire flcfg_pkg::flcfg_adc_t ADC_CTRL,
   input wire logic CONV_DONE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire wr_fl = REQ.wr && REQ.ptr == FAULT_LIMIT_PTR;
   wire wr_tc = REQ.wr && REQ.ptr == TEMP_CTRL_PTR;
   // Restart pulse is followed by the converter reporting busy
   sequence s_kick;
      ADC_CTRL.restart ##[0:2] ADC_CTRL.run;
   endsequence
   a_read_answer: assert property (REQ.rd |=> RVALID) else $error("read unanswered");
   a_valid_cause: assert property (RVALID |-> $past(REQ.rd)) else $error("stray valid");
   a_chop_follow: assert property (wr_fl |-> ##2 CHOP == $past(REQ.wdata[13:12], 2))
      else $error("chop mismatch");
   a_limit_follow: assert property (wr_fl |-> ##2 (!OUT_CTRL.clamp_on || $past(REQ.wdata[6], 2))
      && OUT_CTRL.under_level_code == ($past(REQ.wdata[6], 2) ?
      8'h01 << $past(REQ.wdata[2:0], 2) : 8'h00))
      else $error("under level mismatch");
   a_limit_off: assert property (wr_fl && !REQ.wdata[6] |-> ##2 !OUT_CTRL.clamp_on
      && OUT_CTRL.over_level_code == 8'h00 && OUT_CTRL.under_level_code == 8'h00)
      else $error("clamp while off");
   a_gain_follow: assert property (wr_tc |-> ##2 ADC_CTRL.gain == 4'h1 << $past(REQ.wdata[3:2], 2))
      else $error("gain mismatch");
   a_start_kick: assert property (wr_tc && REQ.wdata[START_BIT] |-> ##[1:3] s_kick)
      else $error("start ignored");
   a_done_pulse: assert property (CONV_DONE |=> !CONV_DONE) else $error("done too long");
   a_fast_gate: assert property (ADC_CTRL.double_speed |-> !ADC_CTRL.internal_sensing_mode
      && !ADC_CTRL.own_ref && ADC_CTRL.res == 2'h0) else $error("double speed misused");
   a_ref_mask: assert property (ADC_CTRL.own_ref |-> ADC_CTRL.ext_ref == 2'h0)
      else $error("ext ref not ignored");
endmodule

/* File: bench/flcfg_top_tb.sv */
// Self-checking testbench for the configuration block
`timescale 1ns/100ps
module flcfg_top_tb;
   import flcfg_pkg::*;
   // Short millisecond keeps conversions to a few hundred cycles
   localparam int CMS = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   flcfg_req_t req = '0;
   flcfg_cmp_t cmp = '0;
   logic [15:0] rdata;
   logic rvalid;
   logic conv_done;
   flcfg_chop_t chop;
   flcfg_out_t oc;
   flcfg_adc_t ac;
   int fail_count = 0;
   int num_checks = 0;
   flcfg_top #(.CYC_MS(CMS)) dut (.CLK(clk), .RST_N(rst_n), .REQ(req), .CMP(cmp), .RDATA(rdata),
      .RVALID(rvalid), .CHOP(chop), .OUT_CTRL(oc), .ADC_CTRL(ac), .CONV_DONE(conv_done));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [4:0] p, logic [15:0] d);
      tick(1);
      req.ptr = p;
      req.wdata = d;
      req.wr = 1'b1;
      tick(1);
      req.wr = 1'b0;
   endtask
   task automatic rchk(logic [4:0] p, logic [15:0] exp);
      tick(1);
      req.ptr = p;
      req.rd = 1'b1;
      tick(1);
      req.rd = 1'b0;
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++) tick(1);
      chk("rvalid", 16'h1, {15'h0, rvalid});
      chk("rdata", exp, rdata);
   endtask
   // A wait that runs out is a mismatch and ends the run
   task automatic wait_done(int ms);
      int n;
      n = 0;
      while (conv_done !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      if (n >= 2000) begin
         chk("done_wait", 16'h1, 16'h0);
         tally_and_finish();
      end
      chk("conv_len", 16'h1, 16'(n >= ms * CMS - 1 && n <= ms * CMS + 5));
   endtask
   task automatic conv(logic [15:0] d, int ms);
      wr(5'h06, d);
      wait_done(ms);
      rchk(5'h06, d & 16'hefff);
   endtask
   task automatic t_regs();
      rchk(5'h05, 16'h0000);
      rchk(5'h06, 16'h0000);
      rchk(5'h07, 16'h0000);
      // Reserved bits are written as zero, as the configuring side must
      wr(5'h05, 16'h3f7f);
      rchk(5'h05, 16'h3f7f);
      wr(5'h06, 16'h2dff);
      rchk(5'h06, 16'h2dff);
      $display("t_regs done");
   endtask
   task automatic t_chop();
      for (int c = 0; c < 4; c++) begin
         wr(5'h05, 16'(c << 12));
         tick(2);
         chk("chop", 16'(c), {14'h0, chop});
      end
      $display("t_chop done");
   endtask
   task automatic t_limits();
      for (int k = 0; k < 8; k++) begin
         wr(5'h05, 16'(64 + k * 9));
         tick(2);
         chk("over", 16'(1 << (k == 7 ? 6 : k)), {8'h0, oc.over_level_code});
         chk("under", 16'(1 << k), {8'h0, oc.under_level_code});
      end
      cmp.over_trip = 1'b1;
      tick(4);
      chk("clamp_on", 16'h1, {15'h0, oc.clamp_on});
      wr(5'h05, 16'h003f);
      tick(2);
      chk("limits_off", 16'h0, {oc.over_level_code, oc.under_level_code});
      chk("clamp_off", 16'h0, {15'h0, oc.clamp_on});
      cmp = '0;
      $display("t_limits done");
   endtask
   task automatic t_faults();
      wr(5'h05, 16'h0a00);
      cmp.outer_trip = 4'h8;
      cmp.inner_trip = 5'h01;
      tick(4);
      chk("outer_force", 16'h3, {14'h0, oc.force_on, oc.force_level});
      cmp = '0;
      // Inner level low against outer level high shows which level drives
      wr(5'h05, 16'h0600);
      cmp.outer_trip = 4'hf;
      tick(4);
      chk("outer_off", 16'h0, {15'h0, oc.force_on});
      cmp.inner_trip = 5'h10;
      tick(4);
      chk("inner_force", 16'h2, {14'h0, oc.force_on, oc.force_level});
      cmp = '0;
      $display("t_faults done");
   endtask
   task automatic t_fields();
      wr(5'h06, 16'h09b9);
      tick(2);
      chk("fields", 16'h0cd1, {4'h0, ac.bias_on, ac.own_ref, ac.ext_ref, ac.mux, ac.gain, ac.res});
      wr(5'h06, 16'h0040);
      tick(2);
      chk("ext_ref", 16'h0104, {4'h0, ac.bias_on, ac.own_ref, ac.ext_ref, ac.mux, ac.gain, ac.res});
      $display("t_fields done");
   endtask
   task automatic t_conv();
      conv(16'h1200, 3);
      chk("intm", 16'h1, {15'h0, ac.internal_sensing_mode});
      conv(16'h1203, 24);
      conv(16'h1000, 6);
      conv(16'h3000, 3);
      chk("dbl", 16'h1, {15'h0, ac.double_speed});
      conv(16'h1100, 8);
      conv(16'h1102, 64);
      wr(5'h06, 16'h1200);
      tick(10);
      conv(16'h1200, 3);
      wr(5'h06, 16'h1600);
      wait_done(3);
      // Step past the done pulse that ended the first wait
      tick(1);
      wait_done(3);
      rchk(5'h06, 16'h1600);
      $display("t_conv done");
   endtask
   initial begin
      tick(10);
      rst_n = 1'b1;
      t_regs();
      t_chop();
      t_limits();
      t_faults();
      t_fields();
      t_conv();
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      rchk(5'h06, 16'h0000);
      rchk(5'h05, 16'h0000);
      tally_and_finish();
   end
endmodule
bind flcfg_top flcfg_checker chk_i (.CLK(CLK), .RST_N(RST_N), .REQ(REQ), .CMP(CMP),
   .RDATA(RDATA), .RVALID(RVALID), .CHOP(CHOP), .OUT_CTRL(OUT_CTRL), .ADC_CTRL(ADC_CTRL),
   .CONV_DONE(CONV_DONE));
